/* common/wdg_consts.vh */
`ifndef WDG_CONSTS_VH
`define WDG_CONSTS_VH

// register byte addresses
`define WDG_ADDR_CTL        12'h060
`define WDG_ADDR_CAUSE      12'h064

// control register field positions
`define WDG_CTL_FLAG        7
`define WDG_CTL_IE          6
`define WDG_CTL_P3          5
`define WDG_CTL_CUE         4
`define WDG_CTL_WDE         3

// reset cause register field positions
`define WDG_CAUSE_WD        3
`define WDG_CAUSE_BROWN     2
`define WDG_CAUSE_PIN       1
`define WDG_CAUSE_POWERON   0

// reset values
`define WDG_CAUSE_RST       4'h1
`define WDG_PERIOD_RST      4'h0

// unlock window length in system clock cycles
`define WDG_UNLOCK_CYC      3'h4

// period select: shortest period in oscillator cycles, highest valid code
`define WDG_BASE_CYC        21'h000800
`define WDG_CODE_MAX        4'h9
`define WDG_OSC_HZ          128000

// axi responses
`define WDG_RESP_OKAY       2'h0
`define WDG_RESP_SLVERR     2'h2

`endif

/* hw/wdg_counter.v */
`include "wdg_consts.vh"
`default_nettype none

// oscillator cycle counter with selectable period
module wdg_counter (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // control
    input  wire       clear,
    input  wire       tick,
    input  wire [3:0] period_code,
    // result
    output reg        timeout
);

    reg  [19:0] cnt_r;      // oscillator cycles since last restart
    wire [19:0] last;       // final count of the selected period

    // last count of a period; reserved codes act as the longest period
    function [19:0] wdg_last;
        input [3:0] code;
        reg   [3:0]  c;
        reg   [20:0] span;
        begin
            c = (code > `WDG_CODE_MAX) ? `WDG_CODE_MAX : code;
            span = (`WDG_BASE_CYC << c) - 21'h000001;
            wdg_last = span[19:0];
        end
    endfunction

    assign last = wdg_last(period_code);

    // count ticks, wrap at period end and flag a timeout
    always @(posedge clk) begin
        if (rst || clear) begin
            cnt_r   <= 20'h00000;   // restart from zero
            timeout <= 1'b0;
        end else if (tick) begin
            // >= so that shortening the period cannot skip the end
            if (cnt_r >= last) begin
                cnt_r   <= 20'h00000;
                timeout <= 1'b1;
            end else begin
                cnt_r   <= cnt_r + 20'h00001;   // one per osc cycle
                timeout <= 1'b0;
            end
        end else begin
            timeout <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* hw/wdg_top.v */
`include "wdg_consts.vh"
`default_nettype none

module wdg_top (
    // clock and power-on reset
    input  wire        clk,
    input  wire        rst,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // watchdog oscillator and processor side
    input  wire        osc_tick,
    input  wire        wd_restart,
    input  wire        global_irq_enable,
    input  wire        irq_vector_taken,
    input  wire        always_on_fuse,
    // other reset sources
    input  wire        pin_reset_event,
    input  wire        brownout_event,
    // results
    output reg         wd_irq,
    output reg         wd_system_reset
);

    localparam SEL_NONE  = 2'b00;   // unmapped
    localparam SEL_CTL   = 2'b01;   // watchdog_control
    localparam SEL_CAUSE = 2'b10;   // reset_cause_status

    // bus slave state
    reg         aw_held_r;          // write address taken, not yet used
    reg  [11:0] aw_addr_r;
    reg         w_held_r;           // write data taken, not yet used
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;

    // watchdog state
    reg         flag_r;             // timeout_irq_flag
    reg         ie_r;               // timeout_irq_enable as written
    reg         wde_r;              // timeout_reset_enable as written
    reg  [3:0]  per_r;              // timeout_period_select
    reg  [2:0]  unl_r;              // unlock window cycles left
    reg  [3:0]  cause_r;            // reset cause flags

    // next values
    reg         flag_nxt;
    reg         ie_nxt;
    reg         wde_nxt;
    reg  [3:0]  per_nxt;
    reg  [2:0]  unl_nxt;
    reg  [3:0]  cause_nxt;
    reg  [7:0]  rd_byte;

    wire        aw_fire;
    wire        w_fire;
    wire        wr_fire;
    wire        ar_fire;
    wire        aw_held_nxt;
    wire        w_held_nxt;
    wire        rvalid_nxt;
    wire [1:0]  wr_sel;
    wire [1:0]  rd_sel;
    wire        wr_ctl;
    wire        wr_cause;
    wire        unlock_act;
    wire        wde_eff;
    wire        ie_eff;
    wire        stopped;
    wire        tmo;
    wire        tmo_irq;
    wire        tmo_rst;
    wire        any_sysrst;
    wire [7:0]  ctl_byte;

    // word address decode, shared by read and write paths
    function [1:0] wdg_decode;
        input [11:0] addr;
        begin
            if (addr[11:2] == `WDG_ADDR_CTL >> 2)
                wdg_decode = SEL_CTL;
            else if (addr[11:2] == `WDG_ADDR_CAUSE >> 2)
                wdg_decode = SEL_CAUSE;
            else
                wdg_decode = SEL_NONE;
        end
    endfunction

    // handshakes; address and data may arrive in either order
    assign aw_fire     = s_axi_awvalid & s_axi_awready;
    assign w_fire      = s_axi_wvalid & s_axi_wready;
    assign wr_fire     = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign ar_fire     = s_axi_arvalid & s_axi_arready;
    assign aw_held_nxt = wr_fire ? 1'b0 : (aw_held_r | aw_fire);
    assign w_held_nxt  = wr_fire ? 1'b0 : (w_held_r | w_fire);
    assign rvalid_nxt  = ar_fire | (s_axi_rvalid & ~s_axi_rready);

    assign wr_sel   = wdg_decode(aw_addr_r);
    assign rd_sel   = wdg_decode(s_axi_araddr);
    // only byte lane 0 carries register bits
    assign wr_ctl   = wr_fire & (wr_sel == SEL_CTL) & w_strb_r[0];
    assign wr_cause = wr_fire & (wr_sel == SEL_CAUSE) & w_strb_r[0];

    // effective mode bits
    assign unlock_act = (unl_r != 3'h0);
    // wd cause flag and fuse both pin the reset enable high
    assign wde_eff  = wde_r | cause_r[`WDG_CAUSE_WD] | always_on_fuse;
    assign ie_eff   = ie_r & ~always_on_fuse;
    assign stopped  = ~wde_eff & ~ie_eff;

    // timeout action by mode
    // interrupt unless combined mode already has one pending
    assign tmo_irq  = tmo & ie_eff & ~(wde_eff & flag_r);
    // reset-only mode, or pending irq unserviced at next timeout
    assign tmo_rst  = tmo & wde_eff & (~ie_eff | flag_r);
    assign any_sysrst = tmo_rst | pin_reset_event | brownout_event;

    assign ctl_byte = {flag_r, ie_eff, per_r[3], unlock_act,
                       wde_eff, per_r[2:0]};

    // period counter; stopped mode and restarts hold it at zero
    wdg_counter u_counter (
        .clk         (clk),
        .rst         (rst),
        .clear       (wd_restart | stopped | any_sysrst),
        .tick        (osc_tick),
        .period_code (per_r),
        .timeout     (tmo)
    );

    // next state of the watchdog and cause registers
    always @* begin
        flag_nxt  = flag_r;
        ie_nxt    = ie_r;
        wde_nxt   = wde_r;
        per_nxt   = per_r;
        cause_nxt = cause_r;
        // unlock window runs down by itself
        unl_nxt   = unlock_act ? unl_r - 3'h1 : 3'h0;
        // vector taken: flag clears, combined mode drops to reset mode
        if (irq_vector_taken) begin
            flag_nxt = 1'b0;
            if (wde_eff)
                ie_nxt = 1'b0;
        end
        if (wr_ctl) begin
            if (w_data_r[`WDG_CTL_FLAG])
                flag_nxt = 1'b0;
            // irq enable is free to write, but locked off by the fuse
            ie_nxt = w_data_r[`WDG_CTL_IE] & ~always_on_fuse;
            if (w_data_r[`WDG_CTL_CUE] && w_data_r[`WDG_CTL_WDE]) begin
                // opening write: arm the window, keep the period
                wde_nxt = 1'b1;
                unl_nxt = `WDG_UNLOCK_CYC;
            end else if (unlock_act) begin
                // change write inside the window takes both fields
                wde_nxt = w_data_r[`WDG_CTL_WDE];
                per_nxt = {w_data_r[`WDG_CTL_P3], w_data_r[2:0]};
                unl_nxt = 3'h0;
            end else begin
                // locked: the reset enable may only be raised
                wde_nxt = wde_r | w_data_r[`WDG_CTL_WDE];
            end
        end
        // writing zero clears a cause flag, writing one keeps it
        if (wr_cause)
            cause_nxt = cause_r & w_data_r[3:0];
        // hardware sets come last so an event beats a same-cycle clear
        if (tmo_irq)
            flag_nxt = 1'b1;
        if (tmo_rst)
            cause_nxt[`WDG_CAUSE_WD] = 1'b1;
        if (brownout_event)
            cause_nxt[`WDG_CAUSE_BROWN] = 1'b1;
        if (pin_reset_event)
            cause_nxt[`WDG_CAUSE_PIN] = 1'b1;
        // a system reset returns control to its initial value;
        // the reset enable then reads back through the cause flag
        if (any_sysrst) begin
            flag_nxt = 1'b0;
            ie_nxt   = 1'b0;
            wde_nxt  = 1'b0;
            per_nxt  = `WDG_PERIOD_RST;
            unl_nxt  = 3'h0;
        end
    end

    // watchdog registers and outputs
    always @(posedge clk) begin
        if (rst) begin
            flag_r          <= 1'b0;
            ie_r            <= 1'b0;
            wde_r           <= 1'b0;
            per_r           <= `WDG_PERIOD_RST;
            unl_r           <= 3'h0;
            // power-on sets its own flag and clears the rest
            cause_r         <= `WDG_CAUSE_RST;
            wd_irq          <= 1'b0;
            wd_system_reset <= 1'b0;
        end else begin
            flag_r          <= flag_nxt;
            ie_r            <= ie_nxt;
            wde_r           <= wde_nxt;
            per_r           <= per_nxt;
            unl_r           <= unl_nxt;
            cause_r         <= cause_nxt;
            // request needs both enables and a pending flag
            wd_irq          <= flag_r & ie_eff & global_irq_enable;
            // one-cycle reset pulse to the reset generator
            wd_system_reset <= tmo_rst;
        end
    end

    // read mux; upper cause bits and bus bits above 7 read zero
    always @* begin
        if (rd_sel == SEL_CTL)
            rd_byte = ctl_byte;
        else if (rd_sel == SEL_CAUSE)
            rd_byte = {4'h0, cause_r};
        else
            rd_byte = 8'h00;
    end

    // axi4-lite write channels
    always @(posedge clk) begin
        if (rst) begin
            aw_held_r     <= 1'b0;
            aw_addr_r     <= 12'h000;
            w_held_r      <= 1'b0;
            w_data_r      <= 32'h00000000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `WDG_RESP_OKAY;
        end else begin
            aw_held_r     <= aw_held_nxt;
            w_held_r      <= w_held_nxt;
            // ready drops while a taken item waits for its partner
            s_axi_awready <= ~aw_held_nxt;
            s_axi_wready  <= ~w_held_nxt;
            if (aw_fire)
                aw_addr_r <= s_axi_awaddr;
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == SEL_NONE) ?
                                `WDG_RESP_SLVERR : `WDG_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read channels; one read in flight
    always @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `WDG_RESP_OKAY;
        end else begin
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_arready <= ~rvalid_nxt;
            if (ar_fire) begin
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= (rd_sel == SEL_NONE) ?
                               `WDG_RESP_SLVERR : `WDG_RESP_OKAY;
            end
        end
    end

endmodule

`default_nettype wire

/* tb/wdg_top_sva.sv */
`default_nettype none
// bus timing and irq/reset outputs seen at the top ports
module wdg_top_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // read channel
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // processor side and results
    input wire logic        global_irq_enable,
    input wire logic        irq_vector_taken,
    input wire logic        always_on_fuse,
    input wire logic        wd_irq,
    input wire logic        wd_system_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic cause_rd_r; // pending read targets the cause register
    // remember the register of each accepted read
    always_ff @(posedge clk) begin
        if (s_axi_arvalid && s_axi_arready)
            cause_rd_r <= s_axi_araddr == 12'h064;
    end
    // read address accepted
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // fuse programmed on two edges running
    sequence s_fuse_held;
        always_on_fuse ##1 always_on_fuse;
    endsequence
    AST_CAUSE_HI: assert property (
        s_axi_rvalid && cause_rd_r |-> s_axi_rdata[31:4] == 28'h0)
        else $error("cause upper bits not zero");
    AST_RD_LAT: assert property (
        s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_RD_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_IRQ_MASK: assert property (
        !global_irq_enable |=> !wd_irq)
        else $error("irq with global enable low");
    AST_VEC_CLR: assert property (
        irq_vector_taken |-> ##2 !wd_irq)
        else $error("irq kept after vector");
    AST_FUSE_NOIRQ: assert property (
        s_fuse_held |-> !wd_irq)
        else $error("irq while fuse programmed");
    AST_RST_PULSE: assert property (
        wd_system_reset |=> !wd_system_reset)
        else $error("system reset longer than one cycle");
    AST_RST_CLR_IRQ: assert property (
        wd_system_reset |-> ##3 !wd_irq)
        else $error("irq survives system reset");
endmodule
bind wdg_top wdg_top_sva i_sva (
    .clk, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .global_irq_enable,
    .irq_vector_taken, .always_on_fuse, .wd_irq, .wd_system_reset
);
`default_nettype wire

/* tb/test_watchdog_and_reset_flags.sv */
`include "wdg_consts.vh"
`default_nettype none
module test_watchdog_and_reset_flags;
    timeunit 1ns;
    timeprecision 1ps;
    // design ports under their own names
    logic        clk, rst, osc_tick, wd_restart, global_irq_enable;
    logic        irq_vector_taken, always_on_fuse, pin_reset_event;
    logic        brownout_event, wd_irq, wd_system_reset;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          n_fail, checks;
    localparam logic [11:0] a_ctl = `WDG_ADDR_CTL;
    localparam logic [11:0] a_cause = `WDG_ADDR_CAUSE;
    wdg_top i_dut (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .osc_tick, .wd_restart,
        .global_irq_enable, .irq_vector_taken, .always_on_fuse,
        .pin_reset_event, .brownout_event, .wd_irq, .wd_system_reset
    );
    always #5 clk = ~clk;
    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bus write; readies may come in either order
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
    endtask
    // bus read, compares the whole word
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        last_resp = s_axi_rresp;
        chk($sformatf("rdata %h", a), e, s_axi_rdata);
    endtask
    // watch irq (rs 0) or system reset (rs 1) for n edges
    task automatic see(input bit rs, input int n, input logic e);
        logic hit;
        hit = 1'b0;
        repeat (n) if (!hit) begin
            @(posedge clk);
            hit = (rs ? wd_system_reset : wd_irq) === 1'b1;
        end
        chk(rs ? "wd_system_reset" : "wd_irq", {31'h0, e}, {31'h0, hit});
    endtask
    // one-cycle vector pulse from the processor
    task automatic vec;
        irq_vector_taken <= 1'b1;
        @(posedge clk);
        irq_vector_taken <= 1'b0;
    endtask
    // reset values, unmapped place refused
    task automatic t_reset;
        rd(a_ctl, 32'h0);
        rd(a_cause, 32'h1);
        // late read ready: the answer must stand until rready is seen
        s_axi_rready <= 1'b0;
        s_axi_araddr <= a_cause;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge clk);
        chk("rvalid late", 32'h1, {31'h0, s_axi_rvalid});
        chk("rdata late", 32'h1, s_axi_rdata);
        rd(12'h100, 32'h0);
        chk("rresp", `WDG_RESP_SLVERR, last_resp);
        wr(12'h100, 8'hff);
        chk("bresp", `WDG_RESP_SLVERR, last_resp);
    endtask
    // other reset sources, clearing the pin flag alone, then the other two
    task automatic t_cause;
        pin_reset_event <= 1'b1;
        brownout_event <= 1'b1;
        @(posedge clk);
        pin_reset_event <= 1'b0;
        brownout_event <= 1'b0;
        rd(a_cause, 32'h7);
        wr(a_cause, 8'hfd);
        rd(a_cause, 32'h5);
        wr(a_cause, 8'h00);
        rd(a_cause, 32'h0);
    endtask
    // interrupt mode: flag, clears, global mask
    task automatic t_irq;
        global_irq_enable <= 1'b1;
        wr(a_ctl, 8'h40);
        see(0, 2100, 1);
        rd(a_ctl, 32'hc0);
        wr(a_ctl, 8'hc0);
        rd(a_ctl, 32'h40);
        see(0, 2100, 1);
        vec();
        rd(a_ctl, 32'h40);
        global_irq_enable <= 1'b0;
        see(0, 2100, 0);
        rd(a_ctl, 32'hc0);
        wr(a_ctl, 8'h80);
        see(1, 2100, 0);
    endtask
    // combined mode, unserviced then serviced
    task automatic t_comb;
        global_irq_enable <= 1'b1;
        wr(a_ctl, 8'h48);
        see(0, 2100, 1);
        see(1, 2100, 1);
        rd(a_cause, 32'h8);
        wr(a_ctl, 8'h18);
        wr(a_ctl, 8'h00);
        rd(a_ctl, 32'h8);
        wr(a_cause, 8'h00);
        rd(a_ctl, 32'h0);
        wr(a_ctl, 8'h48);
        see(0, 2100, 1);
        vec();
        rd(a_ctl, 32'h8);
        see(1, 2100, 1);
        wr(a_cause, 8'h00);
    endtask
    // timed unlock, then a late change refused
    task automatic t_unlock;
        wr(a_ctl, 8'h08);
        wr(a_ctl, 8'h00);
        rd(a_ctl, 32'h8);
        wr(a_ctl, 8'h18);
        wr(a_ctl, 8'h01);
        rd(a_ctl, 32'h1);
        wr(a_ctl, 8'h18);
        rd(a_ctl, 32'h19);
        repeat (6) @(posedge clk);
        wr(a_ctl, 8'h00);
        rd(a_ctl, 32'h9);
        see(1, 3000, 0);
        see(1, 1500, 1);
        wr(a_cause, 8'h00);
    endtask
    // restarts hold off a reset-mode timeout
    task automatic t_restart;
        wr(a_ctl, 8'h08);
        repeat (3) begin
            see(1, 1500, 0);
            wd_restart <= 1'b1;
            @(posedge clk);
            wd_restart <= 1'b0;
        end
        see(1, 2100, 1);
        wr(a_cause, 8'h00);
    endtask
    // programmed fuse locks reset mode
    task automatic t_fuse;
        always_on_fuse <= 1'b1;
        wr(a_ctl, 8'h40);
        rd(a_ctl, 32'h8);
        see(1, 2100, 1);
        always_on_fuse <= 1'b0;
    endtask
    // hang guard, well past the expected run
    initial begin
        #500us;
        n_fail++;
        end_sim();
    end
    initial begin
        {rst, osc_tick, s_axi_bready, s_axi_rready} = 4'hf;
        {clk, wd_restart, global_irq_enable, irq_vector_taken} = 4'h0;
        {always_on_fuse, pin_reset_event, brownout_event} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_cause();
        t_irq();
        t_comb();
        t_unlock();
        t_restart();
        t_fuse();
        end_sim();
    end
endmodule
`default_nettype wire
